// ===== logic/lin_uart_pkg.sv
// constants, types and helpers for the lin/uart command sequencer
package lin_uart_pkg;
   localparam int unsigned CLK_HZ               = 10_000_000;
   localparam int unsigned BAUD_RATE            = 19_200;
   localparam int unsigned BIT_CYCLES           = CLK_HZ / BAUD_RATE;
   localparam int unsigned FRAME_TIMEOUT_US     = 10_000;
   localparam int unsigned FRAME_TIMEOUT_CYCLES = FRAME_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] BIT_M1      = 16'(BIT_CYCLES - 1);
   localparam logic [15:0] HALF_M1     = 16'(BIT_CYCLES / 2 - 1);
   localparam logic [15:0] TX_MID      = 16'(BIT_CYCLES / 2);
   localparam logic [7:0] OFS_CONTROL  = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_ERROR    = 8'h08;
   localparam logic [7:0] OFS_IDENT    = 8'h0C;
   localparam logic [7:0] OFS_LENGTH   = 8'h10;
   localparam logic [7:0] OFS_SELECT   = 8'h14;
   localparam logic [7:0] OFS_DATA     = 8'h18;
   localparam int CTRL_ENABLE_BIT = 3;
   localparam int CTRL_PROTO_BIT  = 4;
   localparam int STAT_RX_DONE    = 0;
   localparam int STAT_TX_DONE    = 1;
   localparam int STAT_ID_DONE    = 2;
   localparam logic [7:0] IDENT_RESET   = 8'h80;
   localparam logic [7:0] LENGTH_RESET  = 8'h00;
   localparam logic [7:0] SYNC_CHAR     = 8'h55;
   localparam int unsigned BREAK_BITS   = 13;
   localparam logic [3:0] TX_BREAK_BITS = 4'(BREAK_BITS + 1);
   localparam logic [3:0] TX_BYTE_BITS  = 4'hA;
   localparam logic [3:0] RX_STOP_BIT   = 4'h9;
   localparam logic [3:0] HDR_FIELDS    = 4'h3;
   localparam logic [3:0] BUF_BYTES     = 4'h8;
   localparam logic [5:0] CLASSIC_ID_MIN = 6'h3C;
   localparam logic [1:0] CMD_IDLE   = 2'h0;
   localparam logic [1:0] CMD_HDR_TX = 2'h1;
   localparam logic [1:0] CMD_RSP_RX = 2'h2;
   localparam logic [1:0] CMD_RSP_TX = 2'h3;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_HDR, SEQ_RSP_TX, SEQ_RSP_RX} seq_e;
   typedef enum logic [1:0] {HR_BREAK, HR_SYNC, HR_PID} hr_e;
   typedef struct packed {
      logic abort;
      logic timeout;
      logic overrun;
      logic framing;
      logic checksum;
      logic parity;
      logic bit_err;
   } err_s;
   // identifier with its two check bits on top
   function automatic logic [7:0] pid_of(input logic [5:0] id);
      return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
   endfunction : pid_of
   // length coded in the identifier for the older protocol
   function automatic logic [3:0] len_of(input logic [5:0] id);
      return (id[5:4] == 2'h3) ? 4'h8 : ((id[5:4] == 2'h2) ? 4'h4 : 4'h2);
   endfunction : len_of
   // sum with end-around carry
   function automatic logic [7:0] chk_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[7:0] + {7'h00, s[8]};
   endfunction : chk_add
endpackage : lin_uart_pkg

// ===== logic/lin_uart_command_sequencer.sv
// lin/uart command sequencer with apb register access and one serial line
// How it works
// - enable bit on, clearing it stops everything
// - lin mode decodes four commands from bits
// - background header receive: break, sync, identifier, parity
// - header received sets flags, old protocol loads length
// - clearing command aborts running function, sets abort
// - header send: 13-bit break, 0x55, identifier
// - header send ends: flags, command idle, old protocol loads length
// - response send starts at once; receive accepted late
// - checksum kind sampled at response start
// - identifiers 60 to 63 always classic checksum
// - response moves n bytes plus checksum, then idle
// - link error stops response, line left recessive
// - new header recorded during response, errors kept
// - data accesses walk buffer from select index
// - uart mode, bits choose receive and transmit
// - uart bypasses buffer, length and select
// - received char sets flag, read clears it
// - shift plus hold stage, overwrite flags overrun
// - uart framing error sets framing flag
// - data write sends char, clears then sets done
// - version bit: 0 newer, 1 older, uart ignores
`timescale 1ns/1ps
`default_nettype none
module lin_uart_command_sequencer
   import lin_uart_pkg::*;
#(
   parameter int unsigned FRAME_TIMEOUT_CYCLES_P = FRAME_TIMEOUT_CYCLES
)
(
   input  wire logic        clock_in,
   input  wire logic        arst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        lin_rx_in,
   output logic             lin_tx_out
);
   logic        enable, proto;
   logic [2:0]  cmd;
   logic        rx_done, tx_done, id_done;
   err_s        err;
   logic [7:0]  ident, length, uart_hold;
   logic [2:0]  sel;
   logic [7:0]  buffer [BUF_BYTES];
   logic        uart_full;
   logic        rx_meta, rx_s, rx_prev, rx_active, rx_valid, rx_framing_error_flag;
   logic [15:0] rx_cnt, tx_cnt;
   logic [3:0]  rx_bit, tx_bits, seq_cnt;
   logic [7:0]  rx_shift, rx_byte, chk, tx_data;
   logic [13:0] tx_shift;
   logic        tx_busy, tx_req, tx_brk;
   seq_e        seq;
   hr_e         hr;
   logic        chk_classic, ft_run;
   logic [19:0] ft_cnt;

   wire access  = psel_in & penable_in;
   wire wr      = access & pwrite_in;
   wire rd      = access & ~pwrite_in;
   wire wr_ctrl = wr && paddr_in == OFS_CONTROL;
   wire wr_data = wr && paddr_in == OFS_DATA;
   wire rd_data = rd && paddr_in == OFS_DATA;
   wire lin_on  = enable & ~cmd[2];
   wire uart_on = enable & cmd[2];
   wire rx_en   = lin_on | (uart_on & cmd[1]);
   wire busy    = tx_busy | (seq != SEQ_IDLE);
   wire rx_fall = rx_prev & ~rx_s;
   wire rx_break   = rx_valid & rx_framing_error_flag & (rx_byte == 8'h00);
   wire hdr_byte   = rx_valid & lin_on & (hr != HR_BREAK);
   wire rsp_byte   = rx_valid & lin_on & (hr == HR_BREAK) & ~rx_break;
   wire hdr_rx_ok  = hdr_byte & (hr == HR_PID) & ~rx_framing_error_flag;
   wire uart_byte  = rx_valid & uart_on & cmd[1];
   wire tx_end     = tx_busy && tx_cnt == 16'h0000 && tx_bits == 4'h1;
   wire tx_start   = tx_req & ~tx_busy;
   wire uart_tx_go = wr_data & uart_on & cmd[0] & ~tx_busy;
   wire bit_err_p  = lin_on && tx_busy && tx_cnt == TX_MID && rx_s != tx_shift[0];
   wire ft_expire  = ft_run && ft_cnt == 20'(FRAME_TIMEOUT_CYCLES_P - 1);
   wire seq_rsp    = (seq == SEQ_RSP_TX) | (seq == SEQ_RSP_RX);
   wire [3:0] len_raw = (seq == SEQ_RSP_TX) ? length[7:4] : length[3:0];
   wire [3:0] rsp_n   = (len_raw > BUF_BYTES) ? BUF_BYTES : len_raw;
   wire seq_abort = seq != SEQ_IDLE && lin_on && cmd[1:0] == CMD_IDLE;
   wire seq_err   = seq != SEQ_IDLE && (bit_err_p || (seq_rsp && ft_expire)
                    || (seq == SEQ_RSP_RX && (rx_break || (rsp_byte && rx_framing_error_flag))));
   logic seq_done;
   always_comb
   begin
      case (seq)
         SEQ_HDR:    seq_done = seq_cnt == HDR_FIELDS && !tx_busy;
         SEQ_RSP_TX: seq_done = seq_cnt == rsp_n + 4'h1 && !tx_busy;
         SEQ_RSP_RX: seq_done = rsp_byte && seq_cnt == rsp_n;
         default:    seq_done = 1'b0;
      endcase
   end
   wire seq_stop    = seq_done | seq_err;
   wire hdr_tx_done = seq == SEQ_HDR && seq_done && !seq_err;
   wire tx_kill     = !enable || seq_abort || seq_err;

   assign pready_out  = 1'b1;
   assign pslverr_out = access && (paddr_in > OFS_DATA || paddr_in[1:0] != 2'h0);

   // apb read data latched in the setup cycle, answered in the access cycle
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         prdata_out <= 32'h0000_0000;
      else if (psel_in && !penable_in && !pwrite_in)
      begin
         case (paddr_in)
            OFS_CONTROL: prdata_out <= {27'h0, proto, enable, cmd};
            OFS_STATUS:  prdata_out <= {27'h0, busy, |err, id_done, tx_done, rx_done};
            OFS_ERROR:   prdata_out <= {25'h0, err};
            OFS_IDENT:   prdata_out <= {24'h0, ident};
            OFS_LENGTH:  prdata_out <= {24'h0, uart_on ? 8'h00 : length};
            OFS_SELECT:  prdata_out <= {29'h0, sel};
            OFS_DATA:    prdata_out <= {24'h0, uart_on ? uart_hold : buffer[sel]};
            default:     prdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // control register; hardware returns the command to idle on completion
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         enable <= 1'b0;
         proto  <= 1'b0;
         cmd    <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            enable <= pwdata_in[CTRL_ENABLE_BIT];
            proto  <= pwdata_in[CTRL_PROTO_BIT];
            cmd    <= pwdata_in[2:0];
         end
         if (seq_stop)
            cmd[1:0] <= CMD_IDLE;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rx_meta <= 1'b1;
         rx_s    <= 1'b1;
         rx_prev <= 1'b1;
      end
      else
      begin
         rx_meta <= lin_rx_in;
         rx_s    <= rx_meta;
         rx_prev <= rx_s;
      end
   end

   // receiver: start bit checked at half bit, then one sample per bit
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rx_active <= 1'b0;
         rx_cnt    <= 16'h0000;
         rx_bit    <= 4'h0;
         rx_shift  <= 8'h00;
         rx_valid  <= 1'b0;
         rx_byte   <= 8'h00;
         rx_framing_error_flag   <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_en)
            rx_active <= 1'b0;
         else if (!rx_active)
         begin
            if (rx_fall)
            begin
               rx_active <= 1'b1;
               rx_cnt    <= HALF_M1;
               rx_bit    <= 4'h0;
            end
         end
         else if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
         else
         begin
            rx_cnt <= BIT_M1;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'h0 && rx_s)
               rx_active <= 1'b0;
            else if (rx_bit == RX_STOP_BIT)
            begin
               rx_active <= 1'b0;
               rx_valid  <= 1'b1;
               rx_byte   <= rx_shift;
               rx_framing_error_flag   <= ~rx_s;
            end
            else if (rx_bit != 4'h0)
               rx_shift <= {rx_s, rx_shift[7:1]};
         end
      end
   end

   // transmitter: the line is bit 0 of the shift register, ones when idle
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         tx_shift <= 14'h3FFF;
         tx_bits  <= 4'h0;
         tx_cnt   <= 16'h0000;
         tx_busy  <= 1'b0;
      end
      else if (tx_kill)
      begin
         tx_shift <= 14'h3FFF;
         tx_busy  <= 1'b0;
      end
      else if (tx_start | uart_tx_go)
      begin
         tx_busy <= 1'b1;
         tx_cnt  <= BIT_M1;
         if (tx_brk)
         begin
            tx_shift <= {1'b1, 13'h0000};
            tx_bits  <= TX_BREAK_BITS;
         end
         else
         begin
            tx_shift <= {4'hF, 1'b1, uart_tx_go ? pwdata_in[7:0] : tx_data, 1'b0};
            tx_bits  <= TX_BYTE_BITS;
         end
      end
      else if (tx_busy)
      begin
         if (tx_cnt != 16'h0000)
            tx_cnt <= tx_cnt - 16'h0001;
         else
         begin
            tx_cnt   <= BIT_M1;
            tx_bits  <= tx_bits - 4'h1;
            tx_shift <= {1'b1, tx_shift[13:1]};
            if (tx_bits == 4'h1)
               tx_busy <= 1'b0;
         end
      end
   end
   assign lin_tx_out = tx_shift[0];

   always_comb
   begin
      tx_req  = 1'b0;
      tx_brk  = 1'b0;
      tx_data = ident;
      case (seq)
         SEQ_HDR:
         begin
            tx_req  = seq_cnt < HDR_FIELDS;
            tx_brk  = seq_cnt == 4'h0;
            tx_data = (seq_cnt == 4'h1) ? SYNC_CHAR : ident;
         end
         SEQ_RSP_TX:
         begin
            tx_req  = seq_cnt <= rsp_n;
            tx_data = (seq_cnt < rsp_n) ? buffer[seq_cnt[2:0]] : ~chk;
         end
         default:
            tx_req = 1'b0;
      endcase
   end

   // function sequencer
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         seq         <= SEQ_IDLE;
         seq_cnt     <= 4'h0;
         chk         <= 8'h00;
         chk_classic <= 1'b0;
      end
      else if (!lin_on || seq_abort || seq_stop)
         seq <= SEQ_IDLE;
      else
      begin
         case (seq)
            SEQ_IDLE:
            begin
               seq_cnt     <= 4'h0;
               chk_classic <= proto || ident[5:0] >= CLASSIC_ID_MIN;
               chk         <= (proto || ident[5:0] >= CLASSIC_ID_MIN) ? 8'h00 : ident;
               case (cmd[1:0])
                  CMD_HDR_TX: seq <= SEQ_HDR;
                  CMD_RSP_TX: seq <= SEQ_RSP_TX;
                  CMD_RSP_RX: seq <= SEQ_RSP_RX;
                  default:    seq <= SEQ_IDLE;
               endcase
            end
            SEQ_HDR:
               if (tx_start)
                  seq_cnt <= seq_cnt + 4'h1;
            SEQ_RSP_TX:
               if (tx_start)
               begin
                  seq_cnt <= seq_cnt + 4'h1;
                  if (seq_cnt < rsp_n)
                     chk <= chk_add(chk, tx_data);
               end
            SEQ_RSP_RX:
               if (rsp_byte)
               begin
                  seq_cnt <= seq_cnt + 4'h1;
                  chk     <= chk_add(chk, rx_byte);
               end
            default:
               seq <= SEQ_IDLE;
         endcase
      end
   end

   // background header acquisition, also during a response
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         hr <= HR_BREAK;
      else if (!lin_on || seq == SEQ_HDR || rx_break)
         hr <= (lin_on && rx_break && seq != SEQ_HDR) ? HR_SYNC : HR_BREAK;
      else if (hdr_byte)
         hr <= (hr == HR_SYNC && rx_byte == SYNC_CHAR && !rx_framing_error_flag) ? HR_PID : HR_BREAK;
   end

   // frame time-out runs from header end until the response ends
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ft_run <= 1'b0;
         ft_cnt <= 20'h00000;
      end
      else if (hdr_rx_ok || hdr_tx_done)
      begin
         ft_run <= 1'b1;
         ft_cnt <= 20'h00000;
      end
      else if (!lin_on || ft_expire || (seq_rsp && seq_stop))
         ft_run <= 1'b0;
      else if (ft_run)
         ft_cnt <= ft_cnt + 20'h00001;
   end

   // identifier and length; the older protocol takes length from the header
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         ident  <= IDENT_RESET;
         length <= LENGTH_RESET;
      end
      else
      begin
         if (wr && paddr_in == OFS_IDENT && !busy)
            ident <= pid_of(pwdata_in[5:0]);
         if (wr && paddr_in == OFS_LENGTH && !busy && !uart_on)
            length <= pwdata_in[7:0];
         if (hdr_rx_ok)
            ident <= rx_byte;
         if (proto && hdr_rx_ok)
            length <= {2{len_of(rx_byte[5:0])}};
         if (proto && hdr_tx_done)
            length <= {2{len_of(ident[5:0])}};
      end
   end

   // response buffer; a response receive has priority over software
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sel <= 3'h0;
         for (int i = 0; i < BUF_BYTES; i++)
            buffer[i] <= 8'h00;
      end
      else
      begin
         if (wr && paddr_in == OFS_SELECT)
            sel <= pwdata_in[2:0];
         else if ((wr_data || rd_data) && lin_on)
            sel <= sel + 3'h1;
         if (seq == SEQ_RSP_RX && rsp_byte && seq_cnt < rsp_n)
            buffer[seq_cnt[2:0]] <= rx_byte;
         else if (wr_data && lin_on)
            buffer[sel] <= pwdata_in[7:0];
      end
   end

   // uart hold stage behind the receive shift stage
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         uart_hold <= 8'h00;
         uart_full <= 1'b0;
      end
      else if (uart_byte)
      begin
         uart_hold <= rx_byte;
         uart_full <= 1'b1;
      end
      else if (rd_data && uart_on)
         uart_full <= 1'b0;
   end

   // flags: clears come first so that a set in the same cycle wins
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rx_done <= 1'b0;
         tx_done <= 1'b0;
         id_done <= 1'b0;
         err     <= '0;
      end
      else
      begin
         if (wr && paddr_in == OFS_STATUS)
         begin
            rx_done <= rx_done & ~pwdata_in[STAT_RX_DONE];
            tx_done <= tx_done & ~pwdata_in[STAT_TX_DONE];
            id_done <= id_done & ~pwdata_in[STAT_ID_DONE];
         end
         if (wr && paddr_in == OFS_ERROR)
            err <= err & ~err_s'(pwdata_in[6:0]);
         if (rd_data && uart_on)
            rx_done <= 1'b0;
         if (uart_tx_go)
            tx_done <= 1'b0;
         if (uart_byte || (seq == SEQ_RSP_RX && seq_done && !seq_err && rx_byte == ~chk))
            rx_done <= 1'b1;
         if ((tx_end && uart_on) || (seq == SEQ_RSP_TX && seq_done && !seq_err))
            tx_done <= 1'b1;
         if (hdr_rx_ok || hdr_tx_done)
            id_done <= 1'b1;
         if (hdr_rx_ok && pid_of(rx_byte[5:0]) != rx_byte)
            err.parity <= 1'b1;
         if (seq_abort)
            err.abort <= 1'b1;
         if (bit_err_p)
            err.bit_err <= 1'b1;
         if (seq_rsp && ft_expire)
            err.timeout <= 1'b1;
         if (seq == SEQ_RSP_RX && seq_done && !seq_err && rx_byte != ~chk)
            err.checksum <= 1'b1;
         if ((seq == SEQ_RSP_RX && seq_err && rx_valid) || (uart_byte && rx_framing_error_flag))
            err.framing <= 1'b1;
         if (uart_byte && uart_full)
            err.overrun <= 1'b1;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   a_disable_idle: assert property (!enable |=> seq == SEQ_IDLE && !tx_busy)
      else $error("disabled controller still busy");
   a_cmd_decode: assert property (lin_on && seq == SEQ_IDLE && cmd[1:0] == CMD_HDR_TX
      |=> seq == SEQ_HDR)
      else $error("header send command not decoded");
   a_abort_flag: assert property (seq_abort |=> err.abort && seq == SEQ_IDLE)
      else $error("abort did not stop and flag");
   a_break_start: assert property (seq == SEQ_HDR && tx_start && seq_cnt == 4'h0
      |=> tx_bits == TX_BREAK_BITS && !lin_tx_out)
      else $error("header did not open with a break");
   a_sync_char: assert property (seq == SEQ_HDR && seq_cnt == 4'h1 |-> tx_data == SYNC_CHAR)
      else $error("sync character wrong");
   a_hdr_done: assert property (hdr_tx_done |=> cmd[1:0] == CMD_IDLE && id_done)
      else $error("header send end not flagged");
   a_classic_id: assert property (seq == SEQ_IDLE && lin_on && cmd[1]
      && ident[5:0] >= CLASSIC_ID_MIN |=> chk_classic && chk == 8'h00)
      else $error("reserved identifier not classic");
   a_err_recessive: assert property (seq_err |=> lin_tx_out && seq == SEQ_IDLE)
      else $error("line not recessive after error");
   a_overrun_flag: assert property (uart_byte && uart_full |=> err.overrun && uart_full)
      else $error("overrun not flagged");
   a_read_clears: assert property (rd_data && uart_on && !uart_byte |=> !rx_done)
      else $error("data read left receive flag");
   a_tx_clear: assert property (uart_tx_go |=> !tx_done && tx_busy)
      else $error("uart send did not start");
   c_hdr_rx: cover property (hdr_rx_ok);
   c_rsp_tx: cover property (seq == SEQ_RSP_TX && seq_done);
   c_rsp_rx: cover property (seq == SEQ_RSP_RX && seq_done);
   c_overrun: cover property (uart_byte && uart_full);
endmodule : lin_uart_command_sequencer
`default_nettype wire

// ===== tb/lin_peer.sv
// serial peer on the shared line: sends frames, records what it hears
`timescale 1ns/1ps
`default_nettype none
module lin_peer
   import lin_uart_pkg::*;
(
   input  wire logic clock_in,
   input  wire logic line_in,
   output logic      drive_out
);
   logic [7:0] got[$];
   logic [7:0] sh;
   // released line sits at the pull-up level
   initial drive_out = 1'b1;
   task automatic bits(input int n);
      repeat (n * BIT_CYCLES) @(posedge clock_in);
   endtask : bits
   // lsb first; a low stop bit makes a framing fault
   task automatic send(input logic [7:0] b, input logic stop);
      drive_out <= 1'b0;
      bits(1);
      for (int i = 0; i < 8; i++)
      begin
         drive_out <= b[i];
         bits(1);
      end
      drive_out <= stop;
      bits(1);
      drive_out <= 1'b1;
      bits(1);
   endtask : send
   // a break reads as a zero byte, waited out before rearming
   initial
   begin
      forever
      begin
         @(negedge line_in);
         repeat (BIT_CYCLES / 2) @(posedge clock_in);
         repeat (8)
         begin
            bits(1);
            sh = {line_in, sh[7:1]};
         end
         got.push_back(sh);
         bits(1);
         wait (line_in === 1'b1);
      end
   end
endmodule : lin_peer
`default_nettype wire

// ===== tb/tb_lin_uart_command_sequencer.sv
// self-checking bench: apb stimulus, serial peer on the line
`timescale 1ns/1ps
`default_nettype none
module tb_lin_uart_command_sequencer
   import lin_uart_pkg::*;
;
   logic        clock_in   = 1'b0;
   logic        arst_n_in  = 1'b0;
   logic        psel_in    = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in  = 1'b0;
   logic [7:0]  paddr_in   = 8'h00;
   logic [31:0] pwdata_in  = 32'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        lin_tx_out;
   logic        drive;
   logic [31:0] q;
   logic [31:0] seed = 32'h58;
   logic [7:0]  b;
   logic [5:0]  id;
   logic        serr;
   int          errors    = 0;
   int          cmp_count = 0;
   wire logic   bus = lin_tx_out & drive;
   always #50 clock_in = ~clock_in;
   lin_uart_command_sequencer uut (.clock_in, .arst_n_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .lin_rx_in(bus), .lin_tx_out);
   lin_peer peer (.clock_in, .line_in(bus), .drive_out(drive));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic [7:0] pidx(input logic [5:0] v);
      return {~(v[1] ^ v[3] ^ v[4] ^ v[5]), v[0] ^ v[1] ^ v[2] ^ v[4], v};
   endfunction : pidx
   function automatic logic [7:0] addc(input logic [7:0] a, input logic [7:0] c);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, c};
      return s[7:0] + {7'h0, s[8]};
   endfunction : addc
   task automatic summarize();
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge clock_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 40);
      q = prdata_out;
      serr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
      if (n >= 40)
      begin
         errors++;
         summarize();
      end
   endtask : apb
   // status reads are cheap, so a long frame is simply polled out
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, a, 32'h0);
         n++;
      end
      while ((q & m) !== m && n < 9000);
      if (n >= 9000)
      begin
         errors++;
         summarize();
      end
   endtask : poll
   initial
   begin
      repeat (3) @(posedge clock_in);
      arst_n_in <= 1'b1;
      @(posedge clock_in);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(i * 4), 32'h0);
         if (i < 7)
            chk(q, (i == 3) ? 32'h80 : 32'h0);
         chk(32'(serr), 32'(i == 7));
      end
      $display("test reset done");
      apb(1'b1, OFS_CONTROL, 32'h0F);
      for (int k = 0; k < 2; k++)
      begin
         b = 8'(xs());
         apb(1'b1, OFS_DATA, 32'(b));
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(q & 32'h2, 32'h0);
         poll(OFS_STATUS, 32'h3);
         chk(32'(peer.got[$]), 32'(b));
         apb(1'b0, OFS_DATA, 32'h0);
         chk(q, 32'(b));
         apb(1'b0, OFS_STATUS, 32'h0);
         chk(q & 32'h1, 32'h0);
      end
      $display("test uart duplex done");
      apb(1'b1, OFS_CONTROL, 32'h0E);
      for (int k = 0; k < 2; k++)
      begin
         b = 8'(xs());
         // second byte overruns the hold stage and carries a low stop bit
         peer.send(b, k == 0);
      end
      apb(1'b0, OFS_ERROR, 32'h0);
      chk(q & 32'h10, 32'h10);
      chk(q & 32'h8, 32'h8);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(q, 32'(b));
      $display("test uart receive done");
      for (int k = 0; k < 2; k++)
      begin
         q = xs();
         id = (k == 1) ? {4'hF, q[1:0]} : 6'(q % 32'h3C);
         apb(1'b1, OFS_CONTROL, 32'h08);
         apb(1'b1, OFS_STATUS, 32'h7);
         apb(1'b1, OFS_IDENT, 32'(id));
         peer.got.delete();
         apb(1'b1, OFS_CONTROL, 32'h09);
         poll(OFS_STATUS, 32'h4);
         chk({peer.got[0], peer.got[1], peer.got[2], 8'h0}, {16'h55, pidx(id), 8'h0});
         apb(1'b0, OFS_CONTROL, 32'h0);
         chk(q & 32'h3, 32'h0);
         apb(1'b1, OFS_SELECT, 32'h0);
         b = 8'(xs());
         apb(1'b1, OFS_DATA, 32'(b));
         apb(1'b1, OFS_LENGTH, 32'h10);
         peer.got.delete();
         apb(1'b1, OFS_CONTROL, 32'h0B);
         poll(OFS_STATUS, 32'h2);
         apb(1'b0, OFS_CONTROL, 32'h0);
         chk(q & 32'h3, 32'h0);
         chk(32'({peer.got[0], peer.got[1]}), 32'({b, ~addc((id > 6'h3B) ? 8'h0 : pidx(id), b)}));
      end
      $display("test lin frames done");
      apb(1'b1, OFS_ERROR, 32'h7F);
      apb(1'b1, OFS_STATUS, 32'h7);
      apb(1'b1, OFS_LENGTH, 32'h0);
      id = 6'(xs() % 32'h3C);
      // header from a remote master: break as a zero byte with low stop
      peer.send(8'h00, 1'b0);
      peer.send(SYNC_CHAR, 1'b1);
      peer.send(pidx(id), 1'b1);
      apb(1'b0, OFS_IDENT, 32'h0);
      chk(q, 32'(pidx(id)));
      apb(1'b1, OFS_CONTROL, 32'h0A);
      // empty response: the enhanced checksum covers the identifier only
      peer.send(~pidx(id), 1'b1);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q & 32'h1F, 32'h05);
      $display("test lin receive done");
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, OFS_ERROR, 32'h7F);
         apb(1'b1, OFS_CONTROL, 32'h0B);
         repeat (100) @(posedge clock_in);
         apb(1'b1, OFS_CONTROL, (k == 1) ? 32'h0 : 32'h8);
         // the kill lands one edge after the write; let it settle
         @(posedge clock_in);
         chk(32'(lin_tx_out), 32'h1);
         apb(1'b0, OFS_ERROR, 32'h0);
         if (k == 0)
            chk(q & 32'h40, 32'h40);
      end
      $display("test abort done");
      summarize();
   end
endmodule : tb_lin_uart_command_sequencer
`default_nettype wire
